// ---- rtl/csaf_defines.svh ----
// register offsets, field positions, reset values and limits of the fifo block
// assumes a 32-bit classic wishbone slave with byte addresses on wb_adr_i
`ifndef CSAF_DEFINES_SVH
`define CSAF_DEFINES_SVH

`define CSAF_OFF_CTRL      8'h00
`define CSAF_OFF_THRESH    8'h04
`define CSAF_OFF_STATUS    8'h08
`define CSAF_OFF_COUNT     8'h0c

`define CSAF_CTRL_OVF_BIT  0
`define CSAF_CTRL_UDF_BIT  1
`define CSAF_CTRL_LOOK_BIT 2
`define CSAF_CTRL_SCLR_BIT 3

`define CSAF_CTRL_OVF_RST  1'b1
`define CSAF_CTRL_UDF_RST  1'b1
`define CSAF_CTRL_LOOK_RST 1'b0

`define CSAF_THR_AF_LSB    0
`define CSAF_THR_AE_LSB    16
`define CSAF_CNT_WR_LSB    0
`define CSAF_CNT_RD_LSB    16

`define CSAF_ST_WR_FULL    0
`define CSAF_ST_WR_EMPTY   1
`define CSAF_ST_RD_FULL    2
`define CSAF_ST_RD_EMPTY   3
`define CSAF_ST_AFULL      4
`define CSAF_ST_AEMPTY     5

`define CSAF_MIN_DEPTH     4
`define CSAF_FIELD_MAX     16
`define CSAF_SYNC_STAGES   2

`endif

// ---- rtl/csaf_pkg.sv ----
// types shared by the fifo block
// assumes the constants header is included by the design files that need offsets
package csaf_pkg;

  typedef logic [31:0] csaf_word_t;

  typedef enum logic {
    CSAF_READ_NORMAL,
    CSAF_READ_LOOKAHEAD
  } csaf_read_style_t;

endpackage

// ---- rtl/csaf_fifo.sv ----
// configurable fifo with single-clock and dual-clock configurations
// assumes producer and consumer logic on the user side, wishbone master for control
`timescale 1ns/10ps
`default_nettype none
`include "csaf_defines.svh"

module csaf_fifo #(
  parameter int WIDTH      = 8,
  parameter int CW         = 4,
  parameter int DEPTH      = 16,
  parameter int DUAL_CLOCK = 0,
  parameter int AF_INIT    = 12,
  parameter int AE_INIT    = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             aclr_i,
  input  wire logic             sclr_i,
  input  wire logic             wr_req_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic             rd_req_i,
  output logic      [WIDTH-1:0] rd_data_o,
  output logic                  wr_full_o,
  output logic                  wr_empty_o,
  output logic      [CW-1:0]    wr_count_o,
  output logic                  rd_full_o,
  output logic                  rd_empty_o,
  output logic      [CW-1:0]    rd_count_o,
  output logic                  almost_full_o,
  output logic                  almost_empty_o,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o
);

  localparam int PW = CW + 1;

  // elaboration-time refusal of shapes the pointer arithmetic cannot serve
  generate
    if (DEPTH < `CSAF_MIN_DEPTH || DEPTH != (1 << CW) || PW > `CSAF_FIELD_MAX || WIDTH < 1) begin : g_bad
      $error("csaf_fifo: depth must be at least four and equal two to the count width");
    end
  endgenerate

  // byte-lane merge used by every writable register
  function automatic csaf_pkg::csaf_word_t csaf_merge(input csaf_pkg::csaf_word_t old_v,
                                                     input csaf_pkg::csaf_word_t new_v,
                                                     input logic [3:0]          sel);
    csaf_pkg::csaf_word_t r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic [WIDTH-1:0]               mem_ff [DEPTH];
  logic [PW-1:0]                  wr_ptr_ff;
  logic [PW-1:0]                  rd_ptr_ff;
  logic [PW-1:0]                  nxt_wr_ptr;
  logic [PW-1:0]                  nxt_rd_ptr;
  logic [PW-1:0]                  rd_sync1_ff;
  logic [PW-1:0]                  rd_sync2_ff;
  logic [PW-1:0]                  wr_sync1_ff;
  logic [PW-1:0]                  wr_sync2_ff;
  logic [PW-1:0]                  wr_view_rd;
  logic [PW-1:0]                  rd_view_wr;
  logic [PW-1:0]                  wr_cnt_ff;
  logic [PW-1:0]                  rd_cnt_ff;
  logic [PW-1:0]                  nxt_wr_cnt;
  logic [PW-1:0]                  nxt_rd_cnt;
  logic [PW-1:0]                  af_thr_ff;
  logic [PW-1:0]                  ae_thr_ff;
  logic                           ovf_prot_ff;
  logic                           udf_prot_ff;
  csaf_pkg::csaf_read_style_t     style_ff;
  logic                           sclr_pulse_ff;
  logic                           clr;
  logic                           wr_ok;
  logic                           rd_ok;
  logic [WIDTH-1:0]               nxt_head;
  logic                           bus_req;
  logic                           bus_wr;
  csaf_pkg::csaf_word_t           ctrl_word;
  csaf_pkg::csaf_word_t           thr_word;
  csaf_pkg::csaf_word_t           status_word;
  csaf_pkg::csaf_word_t           count_word;
  csaf_pkg::csaf_word_t           rd_mux;
  csaf_pkg::csaf_word_t           ctrl_new;
  csaf_pkg::csaf_word_t           thr_new;

  // ---------------- accept logic ----------------
  assign clr   = sclr_i | sclr_pulse_ff;
  assign wr_ok = wr_req_i & ~(ovf_prot_ff & wr_full_o);
  assign rd_ok = rd_req_i & ~(udf_prot_ff & rd_empty_o);

  // each side sees the far pointer only after the two-stage crossing in dual mode
  assign wr_view_rd = (DUAL_CLOCK != 0) ? rd_sync2_ff : nxt_rd_ptr;
  assign rd_view_wr = (DUAL_CLOCK != 0) ? wr_sync2_ff : nxt_wr_ptr;

  always_comb begin
    nxt_wr_ptr = clr ? '0 : wr_ptr_ff + PW'(wr_ok);
    nxt_rd_ptr = clr ? '0 : rd_ptr_ff + PW'(rd_ok);
    nxt_wr_cnt = clr ? '0 : nxt_wr_ptr - wr_view_rd;
    nxt_rd_cnt = clr ? '0 : rd_view_wr - nxt_rd_ptr;
  end

  // pointers, counts and flags; the asynchronous clear needs no hold time
  always_ff @(posedge clk_i or posedge aclr_i) begin
    if (aclr_i) begin
      wr_ptr_ff      <= '0;
      rd_ptr_ff      <= '0;
      wr_cnt_ff      <= '0;
      rd_cnt_ff      <= '0;
      wr_full_o      <= 1'b0;
      wr_empty_o     <= 1'b1;
      rd_full_o      <= 1'b0;
      rd_empty_o     <= 1'b1;
      almost_full_o  <= 1'b0;
      almost_empty_o <= 1'b1;
    end else if (rst_i) begin
      wr_ptr_ff      <= '0;
      rd_ptr_ff      <= '0;
      wr_cnt_ff      <= '0;
      rd_cnt_ff      <= '0;
      wr_full_o      <= 1'b0;
      wr_empty_o     <= 1'b1;
      rd_full_o      <= 1'b0;
      rd_empty_o     <= 1'b1;
      almost_full_o  <= 1'b0;
      almost_empty_o <= 1'b1;
    end else begin
      wr_ptr_ff      <= nxt_wr_ptr;
      rd_ptr_ff      <= nxt_rd_ptr;
      wr_cnt_ff      <= nxt_wr_cnt;
      rd_cnt_ff      <= nxt_rd_cnt;
      wr_full_o      <= (nxt_wr_cnt == PW'(DEPTH));
      wr_empty_o     <= (nxt_wr_cnt == '0);
      rd_full_o      <= (nxt_rd_cnt == PW'(DEPTH));
      rd_empty_o     <= (nxt_rd_cnt == '0);
      almost_full_o  <= (nxt_wr_cnt >= af_thr_ff);
      almost_empty_o <= (nxt_rd_cnt < ae_thr_ff);
    end
  end

  // pointer crossing chains; the first stage feeds only the second
  always_ff @(posedge clk_i or posedge aclr_i) begin
    if (aclr_i) begin
      rd_sync1_ff <= '0;
      rd_sync2_ff <= '0;
      wr_sync1_ff <= '0;
      wr_sync2_ff <= '0;
    end else if (rst_i || clr) begin
      rd_sync1_ff <= '0;
      rd_sync2_ff <= '0;
      wr_sync1_ff <= '0;
      wr_sync2_ff <= '0;
    end else begin
      rd_sync1_ff <= rd_ptr_ff;
      rd_sync2_ff <= rd_sync1_ff;
      wr_sync1_ff <= wr_ptr_ff;
      wr_sync2_ff <= wr_sync1_ff;
    end
  end

  assign wr_count_o = wr_cnt_ff[CW-1:0];
  assign rd_count_o = rd_cnt_ff[CW-1:0];

  // ---------------- storage and output word ----------------
  always_ff @(posedge clk_i) begin
    if (wr_ok && !clr && !rst_i) begin
      mem_ff[wr_ptr_ff[CW-1:0]] <= wr_data_i;
    end
  end

  // a word written into an empty fifo bypasses storage so look-ahead shows it at once
  assign nxt_head = (wr_ok && nxt_rd_ptr == wr_ptr_ff) ? wr_data_i : mem_ff[nxt_rd_ptr[CW-1:0]];

  always_ff @(posedge clk_i or posedge aclr_i) begin
    if (aclr_i) begin
      rd_data_o <= '0;
    end else if (rst_i || clr) begin
      rd_data_o <= '0;
    end else if (style_ff == csaf_pkg::CSAF_READ_LOOKAHEAD) begin
      rd_data_o <= nxt_head;
    end else if (rd_ok) begin
      rd_data_o <= mem_ff[rd_ptr_ff[CW-1:0]];
    end
  end

  // ---------------- wishbone slave ----------------
  assign bus_req = wb_cyc_i & wb_stb_i;
  // writes land on the edge where the master sees ack
  assign bus_wr  = bus_req & wb_we_i & wb_ack_o;

  assign ctrl_word   = {28'h0000000, 1'b0, (style_ff == csaf_pkg::CSAF_READ_LOOKAHEAD), udf_prot_ff, ovf_prot_ff};
  assign thr_word    = (32'(ae_thr_ff) << `CSAF_THR_AE_LSB) | (32'(af_thr_ff) << `CSAF_THR_AF_LSB);
  assign status_word = {26'h0000000, almost_empty_o, almost_full_o, rd_empty_o, rd_full_o, wr_empty_o, wr_full_o};
  assign count_word  = (32'(rd_cnt_ff) << `CSAF_CNT_RD_LSB) | (32'(wr_cnt_ff) << `CSAF_CNT_WR_LSB);
  assign ctrl_new    = csaf_merge(ctrl_word, wb_dat_i, wb_sel_i);
  assign thr_new     = csaf_merge(thr_word, wb_dat_i, wb_sel_i);

  always_comb begin
    case ({wb_adr_i[7:2], 2'b00})
      `CSAF_OFF_CTRL:   rd_mux = ctrl_word;
      `CSAF_OFF_THRESH: rd_mux = thr_word;
      `CSAF_OFF_STATUS: rd_mux = status_word;
      `CSAF_OFF_COUNT:  rd_mux = count_word;
      default:          rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      if (bus_req && !wb_ack_o) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovf_prot_ff <= `CSAF_CTRL_OVF_RST;
      udf_prot_ff <= `CSAF_CTRL_UDF_RST;
      style_ff    <= csaf_pkg::CSAF_READ_NORMAL;
    end else if (bus_wr && {wb_adr_i[7:2], 2'b00} == `CSAF_OFF_CTRL) begin
      ovf_prot_ff <= ctrl_new[`CSAF_CTRL_OVF_BIT];
      udf_prot_ff <= ctrl_new[`CSAF_CTRL_UDF_BIT];
      style_ff    <= ctrl_new[`CSAF_CTRL_LOOK_BIT] ? csaf_pkg::CSAF_READ_LOOKAHEAD : csaf_pkg::CSAF_READ_NORMAL;
    end
  end

  // the clear bit is a self-clearing strobe, it never reads back as one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclr_pulse_ff <= 1'b0;
    end else begin
      sclr_pulse_ff <= bus_wr && {wb_adr_i[7:2], 2'b00} == `CSAF_OFF_CTRL && ctrl_new[`CSAF_CTRL_SCLR_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      af_thr_ff <= PW'(AF_INIT);
      ae_thr_ff <= PW'(AE_INIT);
    end else if (bus_wr && {wb_adr_i[7:2], 2'b00} == `CSAF_OFF_THRESH) begin
      af_thr_ff <= thr_new[`CSAF_THR_AF_LSB +: PW];
      ae_thr_ff <= thr_new[`CSAF_THR_AE_LSB +: PW];
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || aclr_i);

  property p_ovf_drop;
    (ovf_prot_ff && wr_full_o && wr_req_i && !clr) |=> (wr_ptr_ff == $past(wr_ptr_ff));
  endproperty
  a_ovf_drop: assert property (p_ovf_drop) else $error("write accepted while full");

  property p_udf_drop;
    (udf_prot_ff && rd_empty_o && rd_req_i && !clr) |=> (rd_ptr_ff == $past(rd_ptr_ff));
  endproperty
  a_udf_drop: assert property (p_udf_drop) else $error("read accepted while empty");

  property p_afull;
    $stable(af_thr_ff) |-> (almost_full_o == (wr_cnt_ff >= af_thr_ff));
  endproperty
  a_afull: assert property (p_afull) else $error("almost full flag wrong");

  property p_aempty;
    $stable(ae_thr_ff) |-> (almost_empty_o == (rd_cnt_ff < ae_thr_ff));
  endproperty
  a_aempty: assert property (p_aempty) else $error("almost empty flag wrong");

  property p_count_up;
    (DUAL_CLOCK == 0 && wr_ok && !rd_ok && !clr) |=> (wr_cnt_ff == $past(wr_cnt_ff) + PW'(1)) && !wr_empty_o;
  endproperty
  a_count_up: assert property (p_count_up) else $error("count did not rise on write");

  property p_clear;
    clr |=> (wr_cnt_ff == '0) && (rd_cnt_ff == '0) && rd_empty_o && wr_empty_o && !wr_full_o && !rd_full_o;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left state behind");

  property p_store;
    (wr_ok && !clr) |=> (mem_ff[$past(wr_ptr_ff[CW-1:0])] == $past(wr_data_i));
  endproperty
  a_store: assert property (p_store) else $error("written word not stored");

  property p_head;
    (style_ff == csaf_pkg::CSAF_READ_LOOKAHEAD && $stable(style_ff) && udf_prot_ff && !rd_empty_o)
      |-> (rd_data_o == mem_ff[rd_ptr_ff[CW-1:0]]);
  endproperty
  a_head: assert property (p_head) else $error("look-ahead head word wrong");

  c_fill_full: cover property (wr_ok ##1 wr_full_o);
  c_look_read: cover property (style_ff == csaf_pkg::CSAF_READ_LOOKAHEAD && rd_ok);
  c_ovf_try:   cover property (ovf_prot_ff && wr_full_o && wr_req_i);

endmodule
`default_nettype wire

// ---- test/csaf_partner.sv ----
// producer and consumer logic standing beside one fifo, in either configuration
// assumes bench-driven go strobes; ignore_i breaks the flag rules on purpose
`timescale 1ns/10ps
`default_nettype none
module csaf_partner #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             aclr_i,
  input  wire logic             wr_go_i,
  input  wire logic             rd_go_i,
  input  wire logic             ignore_i,
  input  wire logic             wr_full_i,
  input  wire logic             rd_empty_i,
  output logic                  wr_req_o,
  output logic      [WIDTH-1:0] wr_data_o,
  output logic                  rd_req_o
);
  logic [WIDTH-1:0] cnt_ff;

  // request is masked combinationally so the edge that fills the fifo stops it
  assign wr_req_o  = wr_go_i & ~aclr_i & (ignore_i | ~wr_full_i);
  assign rd_req_o  = rd_go_i & (ignore_i | ~rd_empty_i);
  assign wr_data_o = cnt_ff;

  // words are numbered so the bench knows every value that was accepted
  always_ff @(posedge clk_i) begin
    if (rst_i)
      cnt_ff <= '0;
    else if (wr_req_o & ~wr_full_i)
      cnt_ff <= cnt_ff + 1'b1;
  end
endmodule
`default_nettype wire

// ---- test/csaf_fifo_tb.sv ----
// self-checking bench for the fifo block, one instance per configuration
// assumes the partner model drives producer and consumer ports
`timescale 1ns/10ps
`default_nettype none
module csaf_fifo_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        aclr  = 1'b0;
  logic        sclr  = 1'b0;
  logic        wr_go = 1'b0;
  logic        rd_go = 1'b0;
  logic        ign   = 1'b0;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] wdat  = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rdat2;
  logic [3:0]  sel    = 4'hf;
  logic        wr_go2 = 1'b0;
  logic        rd_go2 = 1'b0;
  wire logic        wr_req, rd_req, wr_full, wr_empty, rd_full, rd_empty, afull, aempty, ack;
  wire logic [7:0]  wr_data, rd_data;
  wire logic [3:0]  wr_cnt, rd_cnt;
  wire logic [31:0] wb_q;
  wire logic [5:0]  flags = {wr_full, wr_empty, rd_full, rd_empty, afull, aempty};
  wire logic        wr_req2, rd_req2, wr_full2, wr_empty2, rd_full2, rd_empty2, afull2, aempty2, ack2;
  wire logic [7:0]  wr_data2, rd_data2;
  wire logic [3:0]  wr_cnt2, rd_cnt2;
  wire logic [31:0] wb_q2;
  wire logic [5:0]  flags2 = {wr_full2, wr_empty2, rd_full2, rd_empty2, afull2, aempty2};
  int err_total   = 0;
  int check_count = 0;

  always #2.5 clk_i = ~clk_i;

  csaf_fifo #(.WIDTH(8), .DUAL_CLOCK(0)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .aclr_i(aclr), .sclr_i(sclr), .wr_req_i(wr_req),
    .wr_data_i(wr_data), .rd_req_i(rd_req), .rd_data_o(rd_data), .wr_full_o(wr_full),
    .wr_empty_o(wr_empty), .wr_count_o(wr_cnt), .rd_full_o(rd_full), .rd_empty_o(rd_empty),
    .rd_count_o(rd_cnt), .almost_full_o(afull), .almost_empty_o(aempty), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(wb_q), .wb_ack_o(ack));

  csaf_partner partner (
    .clk_i(clk_i), .rst_i(rst_i), .aclr_i(aclr), .wr_go_i(wr_go), .rd_go_i(rd_go),
    .ignore_i(ign), .wr_full_i(wr_full), .rd_empty_i(rd_empty), .wr_req_o(wr_req),
    .wr_data_o(wr_data), .rd_req_o(rd_req));

  // dual-clock instance shares the register bus and clears, has its own producer and consumer
  csaf_fifo #(.WIDTH(8), .DUAL_CLOCK(1)) dut2 (
    .clk_i(clk_i), .rst_i(rst_i), .aclr_i(aclr), .sclr_i(sclr), .wr_req_i(wr_req2),
    .wr_data_i(wr_data2), .rd_req_i(rd_req2), .rd_data_o(rd_data2), .wr_full_o(wr_full2),
    .wr_empty_o(wr_empty2), .wr_count_o(wr_cnt2), .rd_full_o(rd_full2), .rd_empty_o(rd_empty2),
    .rd_count_o(rd_cnt2), .almost_full_o(afull2), .almost_empty_o(aempty2), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(wb_q2), .wb_ack_o(ack2));

  csaf_partner partner2 (
    .clk_i(clk_i), .rst_i(rst_i), .aclr_i(aclr), .wr_go_i(wr_go2), .rd_go_i(rd_go2),
    .ignore_i(ign), .wr_full_i(wr_full2), .rd_empty_i(rd_empty2), .wr_req_o(wr_req2),
    .wr_data_o(wr_data2), .rd_req_o(rd_req2));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = wb_q;
    rdat2 = wb_q2;
    if (n < 20) chk("wb ack2", 32'h1, {31'h0, ack2});
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (n >= 20) chk("wb ack", 32'h1, 32'h0);
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input string what);
    wb(1'b0, a, 32'h0);
    chk(what, exp, rdat);
  endtask

  task automatic wr_n(input int n);
    @(posedge clk_i);
    wr_go <= 1'b1;
    repeat (n) @(posedge clk_i);
    wr_go <= 1'b0;
    #1;
  endtask

  task automatic rd_one;
    @(posedge clk_i);
    rd_go <= 1'b1;
    @(posedge clk_i);
    rd_go <= 1'b0;
    #1;
  endtask

  task automatic t_reset;
    @(posedge clk_i);
    #1;
    chk("flags", 6'b010101, flags);
    chk("counts", 0, {wr_cnt, rd_cnt});
    rd_reg(8'h00, 32'h3, "ctrl");
    rd_reg(8'h04, 32'h0004000c, "thresh");
    rd_reg(8'h08, 32'h2a, "status");
    rd_reg(8'h0c, 32'h0, "count");
    rd_reg(8'h10, 32'h0, "unmapped");
    $display("test reset done");
  endtask

  task automatic t_fill;
    @(posedge clk_i);
    wr_go <= 1'b1;
    for (int i = 1; i <= 16; i++) begin
      @(posedge clk_i);
      #1;
      chk("wr_count", i % 16, wr_cnt);
      chk("almost_full", i >= 12, afull);
      chk("almost_empty", i < 4, aempty);
      chk("full", i == 16, wr_full);
    end
    // overflow attempt: protection must drop both writes
    @(posedge clk_i);
    ign <= 1'b1;
    repeat (2) @(posedge clk_i);
    wr_go <= 1'b0;
    ign   <= 1'b0;
    rd_reg(8'h0c, 32'h00100010, "count");
    rd_reg(8'h08, 32'h15, "status");
    $display("test fill done");
  endtask

  task automatic t_drain;
    @(posedge clk_i);
    rd_go <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_i);
      #1;
      chk("rd_data", i, rd_data);
      chk("rd_count", 15 - i, rd_cnt);
      chk("almost_empty", (15 - i) < 4, aempty);
      chk("rd_empty", i == 15, rd_empty);
    end
    @(posedge clk_i);
    ign <= 1'b1;
    repeat (2) @(posedge clk_i);
    rd_go <= 1'b0;
    ign   <= 1'b0;
    #1;
    chk("rd_data", 15, rd_data);
    chk("counts", 0, {wr_cnt, rd_cnt});
    chk("flags", 6'b010101, flags);
    $display("test drain done");
  endtask

  task automatic t_look;
    wb(1'b1, 8'h00, 32'h7);
    wr_n(2);
    chk("head", 8'h10, rd_data);
    chk("rd_count", 2, rd_cnt);
    rd_one();
    chk("head", 8'h11, rd_data);
    chk("rd_count", 1, rd_cnt);
    rd_one();
    chk("rd_empty", 1, rd_empty);
    wb(1'b1, 8'h00, 32'h3);
    $display("test lookahead done");
  endtask

  task automatic t_clear;
    wr_n(3);
    chk("wr_count", 3, wr_cnt);
    @(posedge clk_i);
    sclr <= 1'b1;
    @(posedge clk_i);
    sclr <= 1'b0;
    #1;
    chk("counts", 0, {wr_cnt, rd_cnt});
    chk("flags", 6'b010101, flags);
    chk("rd_data", 0, rd_data);
    wr_n(2);
    wb(1'b1, 8'h00, 32'hb);
    repeat (2) @(posedge clk_i);
    #1;
    chk("counts", 0, {wr_cnt, rd_cnt});
    chk("flags", 6'b010101, flags);
    wr_n(3);
    @(posedge clk_i);
    aclr <= 1'b1;
    #1;
    chk("counts", 0, {wr_cnt, rd_cnt});
    chk("flags", 6'b010101, flags);
    @(posedge clk_i);
    aclr <= 1'b0;
    wr_n(1);
    chk("wr_count", 1, wr_cnt);
    $display("test clear done");
  endtask

  // byte lanes on threshold writes, then both protections off and on again
  task automatic t_regs;
    @(posedge clk_i);
    sel <= 4'h4;
    wb(1'b1, 8'h04, 32'h00010001);
    sel <= 4'h1;
    rd_reg(8'h04, 32'h0001000c, "thresh lane2");
    wb(1'b1, 8'h04, 32'h00020001);
    sel <= 4'hf;
    rd_reg(8'h04, 32'h00010001, "thresh lane0");
    #1;
    chk("almost_full", 1, afull);
    chk("almost_empty", 0, aempty);
    wb(1'b1, 8'h04, 32'h0004000c);
    wb(1'b1, 8'h00, 32'h0);
    rd_reg(8'h00, 32'h0, "ctrl off");
    wb(1'b1, 8'h00, 32'h3);
    rd_reg(8'h00, 32'h3, "ctrl on");
    $display("test regs done");
  endtask

  // the far side sees each pointer move three edges late in dual-clock configuration
  task automatic t_dual;
    @(posedge clk_i);
    wr_go2 <= 1'b1;
    repeat (3) @(posedge clk_i);
    wr_go2 <= 1'b0;
    #1;
    chk("wr_count2", 3, wr_cnt2);
    chk("rd_count2", 0, rd_cnt2);
    chk("flags2", 6'b000101, flags2);
    repeat (3) @(posedge clk_i);
    #1;
    chk("rd_count2", 3, rd_cnt2);
    chk("flags2", 6'b000001, flags2);
    wb(1'b0, 8'h0c, 32'h0);
    chk("count2", 32'h00030003, rdat2);
    @(posedge clk_i);
    rd_go2 <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i);
      #1;
      chk("rd_data2", i, rd_data2);
    end
    chk("wr_count2", 3, wr_cnt2);
    @(posedge clk_i);
    rd_go2 <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    chk("counts2", 0, {wr_cnt2, rd_cnt2});
    chk("flags2", 6'b010101, flags2);
    $display("test dual done");
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_fill();
    t_drain();
    t_look();
    t_clear();
    t_regs();
    t_dual();
    give_verdict();
  end

  // the tests need under two hundred cycles; ten thousand means a hang
  initial begin
    #50000;
    err_total++;
    give_verdict();
  end
endmodule
`default_nettype wire
